// ### ocwdr_pkg.sv
// Purpose: Shared constants and types for the overclock watchdog block
// Assumes: Single 25 MHz clock, synchronous active-low reset
// Notes:   Register offsets are byte indices on the control register port
package ocwdr_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned TICK_MS       = 250;  // Base multiplier
  localparam int unsigned LONG_SCALE_S  = 3;    // Long multiplier
  localparam int unsigned PULSE_MS      = 20;   // Reset pulse length
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PULSE_CYC     = CLK_HZ / 1000 * PULSE_MS;
  // Long scale expressed in base ticks (3 s / 250 ms)
  localparam logic [3:0]  LONG_TICKS    = 4'(LONG_SCALE_S * 1000 / TICK_MS);

  // ==========================================================
  // Widths
  localparam int unsigned M_W    = 7;
  localparam int unsigned N_W    = 9;
  localparam int unsigned O_W    = 3;
  localparam int unsigned CNT_W  = 7;  // Holds 7 * 12 ticks

  // ==========================================================
  // Register offsets (byte indices)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h01;
  localparam logic [7:0] OFS_REC_LO = 8'h02;
  localparam logic [7:0] OFS_REC_HI = 8'h03;

  // Control byte field positions
  localparam int unsigned CTRL_ARM   = 0;
  localparam int unsigned CTRL_TMR   = 1;  // Bits 3:1
  localparam int unsigned CTRL_SCALE = 4;
  localparam int unsigned CTRL_RMODE = 5;
  localparam int unsigned CTRL_RSRC  = 6;
  localparam int unsigned CTRL_AUTO  = 7;
  // Status byte field positions
  localparam int unsigned STAT_ALARM = 0;
  localparam int unsigned STAT_SWRST = 1;
  localparam int unsigned STAT_ACT   = 2;
  localparam int unsigned STAT_PULSE = 3;
  localparam int unsigned STAT_SREN  = 4;

  // ==========================================================
  // Reset values
  localparam logic [2:0] TMR_RST   = 3'h0;
  localparam logic       SCALE_RST = 1'b1;
  localparam logic       AUTO_RST  = 1'b1;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [M_W-1:0] m;
    logic [N_W-1:0] n;
    logic [O_W-1:0] o;
  } ocwdr_freq_type;

  typedef struct packed {
    logic       auto_rec;
    logic       rec_src;
    logic       reset_mode;
    logic       scale;
    logic [2:0] timer;
    logic       arm;
  } ocwdr_ctrl_type;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_COUNT,
    WD_DORMANT
  } ocwdr_state_type;

endpackage : ocwdr_pkg

// ### ocwdr_top.sv
// Purpose: Overclock watchdog with timed system reset and PLL recovery
// Assumes: Register port writes are pulses at write completion
// Notes:   Only the CPU PLL setting is ever restored
// Behaviour
// - In table-select mode a lock-up restores only the strapped settings.
// - Watchdog expiry drives system reset low for 20 ms.
// - Arming loads timer field times scale, then counts down.
// - Zero count while armed asserts reset and sets the alarm flag.
// - Reset output usable only when strap sampled low at power good.
// - Changing scale or timer during countdown restarts from new value.
// - After the pulse stay idle until reprogrammed or re-armed.
// - Arm bit resets to zero; each rising edge reloads the counter.
// - Timer field is three bits, default zero, zero is test mode.
// - Alarm flag resets to zero, set on expiry, software may clear.
// - Scale bit picks 250 ms or 3 s; reset value is 3 s.
// - Reset-mode clear gives pulse plus reload; set gives pulse only.
// - Recovery source clear restores strapped values, set uses register.
// - Autorecovery set fills recovery register; clear lets software write.
// - Nine-bit recovery register holds the feedback multiplier.
// - Hardware recovery restores M, N and divider latched at boot.
// - Auto recovery latches M and N on arming, reloads on timeout.
// - Manual recovery restores software N and saved M captured at arm.
// - No recovery keeps present M and N, only resets.
// - A write setting the soft reset bit emits a reset pulse.
// - Soft reset pulse lasts as long as the timeout pulse.
// - Soft reset bit clears itself once the pulse is asserted.
// - Recovery applies to the CPU PLL only, never the SRC PLL.
module ocwdr_top
  import ocwdr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = TICK_CYC,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rstn,
  // Register port, write taken when reg_wr is high
  input  wire logic           reg_wr,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  output logic      [7:0]     reg_rdata,
  // Boot straps and frequency mode inputs
  input  wire logic           power_good_strobe_n,
  input  wire logic           sys_reset_pin_strap,
  input  wire ocwdr_freq_type hw_freq_pins,
  input  wire logic           sw_freq_table_select,
  input  wire ocwdr_freq_type cpu_freq_now,
  // Recovery to the CPU PLL
  output logic                restore_valid,
  output logic                restore_divider,
  output ocwdr_freq_type      restore_freq,
  // System reset pin
  output logic                system_reset_out_n
);

  // ==========================================================
  // Registers
  ocwdr_ctrl_type       ctrl_q;
  ocwdr_state_type      state_q,     state_d;
  logic                 alarm_q;
  logic                 soft_reset_request_q;
  logic [N_W-1:0]       rec_n_q;
  logic [M_W-1:0]       saved_m_q;
  ocwdr_freq_type       boot_freq_q;
  logic                 srst_en_q;
  logic                 pg_prev_q;
  logic [CNT_W-1:0]     cnt_q,       cnt_d;
  logic [22:0]          tick_cnt_q;
  logic [19:0]          pulse_cnt_q;
  logic                 restore_valid_q;
  logic                 restore_div_q;
  ocwdr_freq_type       restore_freq_q;
  logic                 reset_out_q;

  // ==========================================================
  // Decode
  ocwdr_ctrl_type new_ctrl;
  wire logic wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  wire logic wr_stat   = reg_wr && (reg_addr == OFS_STAT);
  wire logic wr_rec_lo = reg_wr && (reg_addr == OFS_REC_LO);
  wire logic wr_rec_hi = reg_wr && (reg_addr == OFS_REC_HI);
  assign new_ctrl = ocwdr_ctrl_type'(reg_wdata);

  // Arming edge and reprogramming while armed
  wire logic arm_rise = wr_ctrl && new_ctrl.arm && !ctrl_q.arm;
  wire logic reprog   = wr_ctrl && new_ctrl.arm
                        && ((new_ctrl.timer != ctrl_q.timer)
                        ||  (new_ctrl.scale != ctrl_q.scale));
  wire logic reload   = arm_rise || reprog;

  // Power good falls: strap and boot frequency are caught here
  wire logic pg_fall  = pg_prev_q && !power_good_strobe_n;

  // ==========================================================
  // Time base
  wire logic tick       = (tick_cnt_q == 23'(TICK_CYCLES - 1));
  wire logic pulse_busy = (pulse_cnt_q != 20'h00000);
  wire logic expire     = (state_q == WD_COUNT) && ctrl_q.arm
                          && tick && (cnt_q == '0);
  wire logic soft_fire  = soft_reset_request_q && !pulse_busy;

  // Load value: timer field times the selected multiplier
  function automatic logic [CNT_W-1:0] load_val(
    input logic [2:0] tmr,
    input logic       scl
  );
    logic [3:0] mul;
    mul = scl ? LONG_TICKS : 4'h1;
    // Widen both factors first so the product is never cut to four bits
    return CNT_W'(tmr) * CNT_W'(mul);
  endfunction : load_val

  // ==========================================================
  // Countdown state machine
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      WD_IDLE, WD_DORMANT: begin
        // Dormant after a pulse until reprogrammed or re-armed
        if (reload) begin
          state_d = WD_COUNT;
          cnt_d   = load_val(new_ctrl.timer, new_ctrl.scale);
        end
      end
      WD_COUNT: begin
        if (wr_ctrl && !new_ctrl.arm) begin
          state_d = WD_IDLE;
        end else if (reload) begin
          cnt_d = load_val(new_ctrl.timer, new_ctrl.scale);
        end else if (expire) begin
          state_d = WD_DORMANT;
        end else if (tick) begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
    endcase
  end

  // ==========================================================
  // Recovery selection
  ocwdr_freq_type rec_freq;
  wire logic use_hw  = sw_freq_table_select || !ctrl_q.rec_src;
  wire logic do_rec  = expire && !ctrl_q.reset_mode;
  // Auto and manual both use saved M with the recovery N register
  assign rec_freq = use_hw ? boot_freq_q
                           : ocwdr_freq_type'{m: saved_m_q, n: rec_n_q,
                                              o: cpu_freq_now.o};

  // ==========================================================
  // State, counter and prescaler
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q    <= WD_IDLE;
      cnt_q      <= '0;
      tick_cnt_q <= '0;
      pg_prev_q  <= 1'b1;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      pg_prev_q  <= power_good_strobe_n;
      // Prescaler restarts on reload so the first tick is a full period
      if (tick || reload) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 23'h000001;
      end
    end
  end

  // Control register; arm resets low, scale high, timer to test code
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= '{auto_rec: AUTO_RST, rec_src: 1'b0, reset_mode: 1'b0,
                  scale: SCALE_RST, timer: TMR_RST, arm: 1'b0};
    end else if (wr_ctrl) begin
      ctrl_q <= new_ctrl;
    end
  end

  // Alarm flag; writing zero clears it but a same-cycle expiry wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alarm_q <= 1'b0;
    end else if (expire) begin
      alarm_q <= 1'b1;
    end else if (wr_stat && !reg_wdata[STAT_ALARM]) begin
      alarm_q <= 1'b0;
    end
  end

  // Soft reset request; self-clears once its pulse has started
  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_reset_request_q <= 1'b0;
    end else if (wr_stat && reg_wdata[STAT_SWRST]) begin
      soft_reset_request_q <= 1'b1;
    end else if (soft_fire || expire) begin
      soft_reset_request_q <= 1'b0;
    end
  end

  // Recovery N register and hidden saved M
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rec_n_q   <= '0;
      saved_m_q <= '0;
    end else begin
      if (arm_rise) begin
        saved_m_q <= cpu_freq_now.m;
      end
      if (arm_rise && ctrl_q.auto_rec) begin
        rec_n_q <= cpu_freq_now.n;
      end else if (!ctrl_q.auto_rec && wr_rec_lo) begin
        rec_n_q[7:0] <= reg_wdata;
      end else if (!ctrl_q.auto_rec && wr_rec_hi) begin
        rec_n_q[8] <= reg_wdata[0];
      end
    end
  end

  // Boot capture of strap and pin-selected frequency
  always_ff @(posedge clk) begin
    if (!rstn) begin
      srst_en_q   <= 1'b0;
      boot_freq_q <= '0;
    end else if (pg_fall) begin
      srst_en_q   <= !sys_reset_pin_strap;
      boot_freq_q <= hw_freq_pins;
    end
  end

  // ==========================================================
  // Reset pulse shared by timeout and soft request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pulse_cnt_q <= '0;
      reset_out_q <= 1'b1;
    end else begin
      if (expire || soft_fire) begin
        pulse_cnt_q <= 20'(PULSE_CYCLES);
      end else if (pulse_busy) begin
        pulse_cnt_q <= pulse_cnt_q - 20'h00001;
      end
      // Low only while counting and enabled by strap
      reset_out_q <= !(srst_en_q
                     && (expire || soft_fire
                     || (pulse_cnt_q > 20'h00001)));
    end
  end

  // Restore strobe toward the CPU PLL only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      restore_valid_q <= 1'b0;
      restore_div_q   <= 1'b0;
      restore_freq_q  <= '0;
    end else begin
      restore_valid_q <= do_rec;
      if (do_rec) begin
        restore_freq_q <= rec_freq;
        restore_div_q  <= use_hw;
      end
    end
  end

  // ==========================================================
  // Readback
  logic [7:0] stat_byte;
  assign stat_byte = {3'h0, srst_en_q, pulse_busy,
                      (state_q == WD_COUNT),
                      soft_reset_request_q, alarm_q};

  always_comb begin
    unique case (reg_addr)
      OFS_CTRL:   reg_rdata = ctrl_q;
      OFS_STAT:   reg_rdata = stat_byte;
      OFS_REC_LO: reg_rdata = rec_n_q[7:0];
      OFS_REC_HI: reg_rdata = {7'h00, rec_n_q[8]};
      default:    reg_rdata = 8'h00;  // Unmapped reads zero
    endcase
  end

  // ==========================================================
  // Outputs
  assign system_reset_out_n = reset_out_q;
  assign restore_valid      = restore_valid_q;
  assign restore_divider    = restore_div_q;
  assign restore_freq       = restore_freq_q;

endmodule : ocwdr_top

// ### ocwdr_monitor.sv
// Purpose: Port checker for the overclock watchdog
// Assumes: Bound to ocwdr_top; one clock domain
// Notes:   Helper logic copies the boot latch and times reset pulses
module ocwdr_monitor
  import ocwdr_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = 5
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           rstn,
  // Register port
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_rdata,
  // Straps and frequencies
  input wire logic           power_good_strobe_n,
  input wire logic           sys_reset_pin_strap,
  input wire ocwdr_freq_type hw_freq_pins,
  input wire logic           sw_freq_table_select,
  input wire ocwdr_freq_type cpu_freq_now,
  // Outputs under check
  input wire logic           restore_valid,
  input wire logic           restore_divider,
  input wire ocwdr_freq_type restore_freq,
  input wire logic           system_reset_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Helpers: strap copy taken at power good, low-cycle counter
  logic           pg_q;
  logic           sren_q;
  logic [19:0]    low_q;
  ocwdr_freq_type boot_q;
  always_ff @(posedge clk) begin
    pg_q <= power_good_strobe_n;
    if (!rstn) begin
      sren_q <= 1'b0;
    end else if (pg_q && !power_good_strobe_n) begin
      sren_q <= !sys_reset_pin_strap;
      boot_q <= hw_freq_pins;
    end
  end
  always_ff @(posedge clk) begin
    low_q <= system_reset_out_n ? 20'h0 : low_q + 20'h1;
  end
  // ==========================================================
  // Assertions
  a_pulse_len: assert property (
    $rose(system_reset_out_n) |-> low_q == PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_pulse_max: assert property (low_q <= PULSE_CYCLES)
    else $error("reset pulse too long");
  a_restore_once: assert property (
    restore_valid |=> !restore_valid)
    else $error("restore strobe longer than one cycle");
  a_restore_rst: assert property (
    restore_valid && sren_q |-> $fell(system_reset_out_n))
    else $error("restore without reset pulse start");
  a_strap_quiet: assert property (
    !sren_q |-> system_reset_out_n)
    else $error("reset driven while strap disabled");
  a_ctrl_reset: assert property (
    !$past(rstn) && reg_addr == OFS_CTRL |-> reg_rdata == 8'h90)
    else $error("control reset value wrong");
  a_restore_hold: assert property (
    !restore_valid |-> $stable(restore_freq))
    else $error("restore setting moved without strobe");
  a_restore_hw: assert property (
    restore_valid && sw_freq_table_select |->
      restore_divider && restore_freq == boot_q)
    else $error("table mode did not restore boot setting");
  a_keep_divider: assert property (
    restore_valid && !restore_divider |->
      restore_freq.o == cpu_freq_now.o)
    else $error("saved restore changed output divider");
endmodule : ocwdr_monitor

// ### ocwdr_board.sv
// Purpose: Board model: power good, straps, reset pulse timing
// Assumes: Straps are valid only around the power good edge
// Notes:   Straps flip after sampling so a late latch shows up
module ocwdr_board
  import ocwdr_pkg::*;
#(
  parameter ocwdr_freq_type BOOT = 19'h2A5B3
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rstn,
  // Boot straps
  output logic                power_good_strobe_n,
  output logic                sys_reset_pin_strap,
  output ocwdr_freq_type      hw_freq_pins,
  // Reset pin watch
  input  wire logic           system_reset_out_n,
  output int                  pulses,
  output int                  last_len
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  int len_q = 0;
  int len = 0;
  assign pulses = cnt;
  assign last_len = len_q;
  // ==========================================================
  // Boot: strap low for watchdog use, then release the straps
  initial begin
    power_good_strobe_n = 1'b1;
    sys_reset_pin_strap = 1'b0;
    hw_freq_pins = BOOT;
    @(posedge rstn);
    repeat (3) @(negedge clk);
    power_good_strobe_n = 1'b0;
    repeat (2) @(negedge clk);
    sys_reset_pin_strap = 1'b1;
    hw_freq_pins = ~BOOT;
  end
  // Count and time every low pulse on the reset pin
  always @(posedge clk) begin
    if (system_reset_out_n === 1'b0) begin
      len++;
    end else if (len > 0) begin
      cnt++;
      len_q = len;
      len = 0;
    end
  end
endmodule : ocwdr_board

// ### ocwdr_top_bench.sv
// Purpose: Self-checking bench for the overclock watchdog
// Assumes: Short tick and pulse counts for simulation
// Notes:   Bench model tracks control, saved M and recovery N
module ocwdr_top_bench
  import ocwdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 10;
  localparam int P = 5;
  localparam ocwdr_freq_type BOOT = 19'h2A5B3;
  localparam logic [14:0] MODES = 15'h6C8C; // Auto,src,mode for passes 0 to 4
  logic           clk, rstn, reg_wr, sel, pgn, strap, rv, rdiv, rso;
  logic [7:0]     addr, wdata, rdata, ctl, c;
  logic [6:0]     sm;
  logic [8:0]     rn;
  logic [2:0]     mb;
  ocwdr_freq_type cpu, hwp, rf;
  int             mismatches, compares, seed, pulses, plen, n;
  ocwdr_top #(.TICK_CYCLES(T), .PULSE_CYCLES(P)) ocwdr_top_i (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .power_good_strobe_n(pgn),
    .sys_reset_pin_strap(strap), .hw_freq_pins(hwp),
    .sw_freq_table_select(sel), .cpu_freq_now(cpu),
    .restore_valid(rv), .restore_divider(rdiv), .restore_freq(rf),
    .system_reset_out_n(rso));
  ocwdr_board #(.BOOT(BOOT)) ocwdr_board_i (
    .clk(clk), .rstn(rstn), .power_good_strobe_n(pgn),
    .sys_reset_pin_strap(strap), .hw_freq_pins(hwp),
    .system_reset_out_n(rso), .pulses(pulses), .last_len(plen));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s %0h/%0h", $time, what, got, exp);
    end
  endtask : chk
  // Write cycle; the model follows arm rises and manual N writes
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    if (a == OFS_CTRL && d[0] && !ctl[0]) begin
      sm = cpu.m;
      if (ctl[7]) rn = cpu.n;
    end
    if (a == OFS_CTRL) ctl = d;
    if (!ctl[7] && a == OFS_REC_LO) rn[7:0] = d;
    if (!ctl[7] && a == OFS_REC_HI) rn[8] = d[0];
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input string what);
    @(negedge clk);
    addr = a;
    #1;
    chk(rdata, e, what);
  endtask : rd
  // Edges from the write until the reset pin goes low
  task automatic low_after(input int e);
    n = 0;
    while (rso !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, e, "reset delay");
  endtask : low_after
  task automatic settle();
    repeat (P + 2) @(posedge clk);
    chk(plen, P, "pulse length");
  endtask : settle
  task automatic quiet(input int k);
    int p;
    p = pulses;
    repeat (k) @(posedge clk);
    chk(pulses, p, "idle");
  endtask : quiet
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    summarize();
  end
  // ==========================================================
  // Scenarios
  initial begin
    {reg_wr, addr, wdata, sel, cpu, rstn, sm, rn} = '0;
    {mismatches, compares} = '0;
    seed = 43;
    ctl = 8'h90;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    rd(OFS_CTRL, 8'h90, "ctrl reset");
    rd(OFS_STAT, 8'h10, "stat reset");
    rd(8'h07, 8'h00, "unmapped");
    for (int t = 0; t < 8; t++) begin
      cpu = 19'($random(seed));
      sel = (t == 4);
      mb = (t < 5) ? 3'(MODES >> (3 * t)) : 3'($random(seed));
      c = {mb, 1'b0, 3'(t), 1'b1};
      wr(OFS_CTRL, c & 8'hFE);
      if (!c[7]) begin
        wr(OFS_REC_LO, 8'($random(seed)));
        wr(OFS_REC_HI, 8'($random(seed)));
      end
      wr(OFS_CTRL, c);
      low_after((t + 1) * T);
      chk(rv, !c[5], "restore strobe");
      if (!c[5] && (sel || !c[6])) chk({rdiv, rf}, {1'b1, BOOT}, "hw");
      if (!c[5] && !sel && c[6]) chk({rdiv, rf}, {1'b0, sm, rn, cpu.o}, "sv");
      rd(OFS_STAT, 8'h19, "alarm");
      if (c[7]) begin
        rd(OFS_REC_LO, rn[7:0], "auto n");
        wr(OFS_REC_LO, 8'hFF);
        rd(OFS_REC_LO, rn[7:0], "refused");
      end
      settle();
      quiet(40);
      wr(OFS_STAT, 8'h00);
      rd(OFS_STAT, 8'h10, "alarm clear");
    end
    wr(OFS_CTRL, 8'h0D);
    repeat (30) @(posedge clk);
    wr(OFS_CTRL, 8'h05);
    low_after(3 * T);
    settle();
    wr(OFS_CTRL, 8'h32);
    wr(OFS_CTRL, 8'h33);
    low_after(13 * T);
    chk(rv, 1'b0, "pulse only");
    settle();
    wr(OFS_CTRL, 8'h22);
    wr(OFS_CTRL, 8'h23);
    repeat (10) @(posedge clk);
    wr(OFS_CTRL, 8'h22);
    quiet(60);
    wr(OFS_STAT, 8'h02);
    low_after(1);
    rd(OFS_STAT, 8'h18, "soft bit");
    settle();
    summarize();
  end
endmodule : ocwdr_top_bench
bind ocwdr_top ocwdr_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) mon_i (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .power_good_strobe_n(power_good_strobe_n),
  .sys_reset_pin_strap(sys_reset_pin_strap),
  .hw_freq_pins(hw_freq_pins), .cpu_freq_now(cpu_freq_now),
  .sw_freq_table_select(sw_freq_table_select),
  .restore_valid(restore_valid), .restore_divider(restore_divider),
  .restore_freq(restore_freq), .system_reset_out_n(system_reset_out_n));
